/* design/swc_pkg.sv */
// constants and types of the sleep, watchdog and wake controller
package swc_pkg;
    // register port shape
    localparam int SWC_ADDR_W = 14;
    localparam int SWC_DATA_W = 8;

    // register offsets
    localparam logic [13:0] SWC_OFF_STATUS = 14'h0003;
    localparam logic [13:0] SWC_OFF_IRQCTL = 14'h000B;
    localparam logic [13:0] SWC_OFF_OPTION = 14'h0081;
    localparam logic [13:0] SWC_OFF_CONFIG = 14'h2007;

    // timer option register fields
    localparam int SWC_OPT_EDGE   = 6;
    localparam int SWC_OPT_PSA    = 3;
    localparam int SWC_OPT_PS_LSB = 0;
    localparam int SWC_PS_W       = 3;

    // interrupt control register fields
    localparam int SWC_IC_GIE  = 7;
    localparam int SWC_IC_PEIE = 6;
    localparam int SWC_IC_TIMER_ZERO_OVERFLOW_ENABLE = 5;
    localparam int SWC_IC_EXT_EDGE_ENABLE = 4;
    localparam int SWC_IC_PORT_CHANGE_ENABLE = 3;
    localparam int SWC_IC_TIMER_ZERO_OVERFLOW_FLAG = 2;
    localparam int SWC_IC_EXT_EDGE_FLAG = 1;
    localparam int SWC_IC_PORT_CHANGE_FLAG = 0;

    // status and configuration fields
    localparam int SWC_ST_TO   = 4;
    localparam int SWC_ST_PD   = 3;
    localparam int SWC_CFG_WATCHDOG_ENABLE_FUSE = 2;

    // reset values
    localparam logic [7:0] SWC_OPTION_RST = 8'hFF;
    localparam logic [7:0] SWC_IRQCTL_RST = 8'h00;
    localparam logic [7:0] SWC_CONFIG_RST = 8'h00;

    // interrupt vector
    localparam logic [12:0] SWC_VECTOR_ADDR = 13'h0004;

    // pin bundle positions
    localparam int SWC_PIN_EXT  = 0;
    localparam int SWC_PIN_PB   = 1;
    localparam int SWC_PIN_MASTER_CLEAR_N = 5;
    localparam int SWC_PIN_RC   = 6;
    localparam int SWC_PINS     = 7;

    // timing
    localparam int SWC_CLK_NS        = 5;
    localparam int SWC_TCY_NS        = 20;
    localparam int SWC_TCY_CLKS      = SWC_TCY_NS / SWC_CLK_NS;
    localparam int SWC_IRQ_LAT_TCY   = 3;
    localparam int SWC_SYNC_PIPE     = 6;
    localparam int SWC_IRQ_WAIT_CLKS = SWC_IRQ_LAT_TCY * SWC_TCY_CLKS
                                       - SWC_SYNC_PIPE;
    localparam int SWC_WDT_PERIOD_US = 18000;

    // run or sleep
    typedef enum logic [0:0] {
        SWC_RUN    = 1'b0,
        SWC_ASLEEP = 1'b1
    } swc_mode_t;

    // whole block state
    typedef struct packed {
        logic [SWC_PINS-1:0] s1;
        logic [SWC_PINS-1:0] s2;
        logic [SWC_PINS-1:0] s3;
        logic [SWC_PINS-1:0] filt;
        logic [SWC_PINS-1:0] prev;
        logic [1:0]          phase;
        swc_mode_t           mode;
        logic [7:0]          option;
        logic [7:0]          irqctl;
        logic [7:0]          cfg_word;
        logic                cfg_loaded;
        logic                pd_n;
        logic                to_n;
        logic [6:0]          pre_cnt;
        logic [15:0]         wdt_cnt;
        logic                irq_pend;
        logic [3:0]          irq_wait;
        logic                irq_vector;
        logic                wake;
        logic                reset_req;
        logic [7:0]          rdata;
    } swc_state_t;
endpackage : swc_pkg

/* design/swc_sleep_watchdog_wake_control.sv */
// sleep, watchdog and wake-up controller with core interrupt flags
`timescale 1ns/1ps
module swc_sleep_watchdog_wake_control #(
    parameter int unsigned RC_KHZ = 100
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // register port
    input  wire logic [swc_pkg::SWC_ADDR_W-1:0] reg_addr,
    input  wire logic [swc_pkg::SWC_DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [swc_pkg::SWC_DATA_W-1:0] reg_rdata,
    // pins from outside
    input  wire logic                        ext_edge_pin,
    input  wire logic [3:0]                  port_b_hi,
    input  wire logic                        master_clear_n,
    input  wire logic                        wdt_rc_osc,
    // core events on this clock
    input  wire logic                        clear_watchdog_instr,
    input  wire logic                        sleep_instr,
    input  wire logic                        retfie_instr,
    input  wire logic                        timer_zero_rollover,
    input  wire logic                        periph_wake_req,
    input  wire logic [7:0]                  cfg_fuse_bits,
    // core control out
    output logic                             irq_vector_load,
    output logic                             push_return_pc,
    output logic      [12:0]                 vector_addr,
    output logic                             wake_pulse,
    output logic                             device_reset_req,
    output logic                             sleep_active,
    output logic                             osc_drive_en,
    output logic                             io_hold
);
    import swc_pkg::*;

    // watchdog base count derived from period and RC rate
    localparam logic [15:0] WDT_BASE_TICKS =
        16'(SWC_WDT_PERIOD_US * RC_KHZ / 1000);

    swc_state_t st_q;
    swc_state_t st_d;

    logic       master_clear_n_act;
    logic       ext_hit;
    logic       port_hit;
    logic       rc_tick;
    logic       wdt_on;
    logic [6:0] pre_lim;
    logic       wdt_tick;
    logic       wdt_timeout;
    logic       wake_cond;
    logic       irq_any;
    logic       sleep_go;
    logic       wdt_clear;

    // decoded events from current state
    always_comb begin
        master_clear_n_act = ~st_q.filt[SWC_PIN_MASTER_CLEAR_N];
        ext_hit  = st_q.option[SWC_OPT_EDGE]
                   ? (st_q.filt[SWC_PIN_EXT] & ~st_q.prev[SWC_PIN_EXT])
                   : (~st_q.filt[SWC_PIN_EXT] & st_q.prev[SWC_PIN_EXT]);
        port_hit = |(st_q.filt[SWC_PIN_PB+:4] ^ st_q.prev[SWC_PIN_PB+:4]);
        rc_tick  = st_q.filt[SWC_PIN_RC] & ~st_q.prev[SWC_PIN_RC];
        wdt_on   = st_q.cfg_loaded & st_q.cfg_word[SWC_CFG_WATCHDOG_ENABLE_FUSE];
        pre_lim  = 7'((8'h01 << st_q.option[SWC_OPT_PS_LSB+:SWC_PS_W])
                      - 8'h01);
        // prescaler in front of base count
        wdt_tick = wdt_on & rc_tick
                   & (~st_q.option[SWC_OPT_PSA] | (st_q.pre_cnt == pre_lim));
        wdt_timeout = wdt_tick & (st_q.wdt_cnt == WDT_BASE_TICKS - 16'h0001);
        wake_cond = (st_q.irqctl[SWC_IC_EXT_EDGE_FLAG] & st_q.irqctl[SWC_IC_EXT_EDGE_ENABLE])
                  | (st_q.irqctl[SWC_IC_PORT_CHANGE_FLAG] & st_q.irqctl[SWC_IC_PORT_CHANGE_ENABLE])
                  | (periph_wake_req & st_q.irqctl[SWC_IC_PEIE]);
        irq_any   = wake_cond
                  | (st_q.irqctl[SWC_IC_TIMER_ZERO_OVERFLOW_FLAG] & st_q.irqctl[SWC_IC_TIMER_ZERO_OVERFLOW_ENABLE]);
        // a pending enabled source turns sleep into a no-op
        sleep_go  = sleep_instr & (st_q.mode == SWC_RUN) & ~irq_any;
        wdt_clear = clear_watchdog_instr | sleep_go;
    end

    // next state
    always_comb begin
        st_d            = st_q;
        st_d.irq_vector = 1'b0;
        st_d.wake       = 1'b0;
        st_d.reset_req  = 1'b0;
        st_d.rdata      = 8'h00;
        st_d.phase      = st_q.phase + 2'h1;
        // three-stage pin sampling, change once stages two and three agree
        st_d.s1   = {wdt_rc_osc, master_clear_n, port_b_hi, ext_edge_pin};
        st_d.s2   = st_q.s1;
        st_d.s3   = st_q.s2;
        st_d.prev = st_q.filt;
        for (int i = 0; i < SWC_PINS; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.filt[i] = st_q.s3[i];
            end
        end
        // fuse word caught once after reset release
        if (!st_q.cfg_loaded) begin
            st_d.cfg_word   = cfg_fuse_bits;
            st_d.cfg_loaded = 1'b1;
        end
        // register writes, decoded by address
        if (reg_wr) begin
            if (reg_addr == SWC_OFF_OPTION) begin
                st_d.option = reg_wdata;
            end else if (reg_addr == SWC_OFF_IRQCTL) begin
                st_d.irqctl = reg_wdata;
            end
        end
        // register reads, data in the next cycle only
        if (reg_rd) begin
            if (reg_addr == SWC_OFF_OPTION) begin
                st_d.rdata = st_q.option;
            end else if (reg_addr == SWC_OFF_IRQCTL) begin
                st_d.rdata = st_q.irqctl;
            end else if (reg_addr == SWC_OFF_STATUS) begin
                st_d.rdata = {3'h0, st_q.to_n, st_q.pd_n, 3'h0};
            end else if (reg_addr == SWC_OFF_CONFIG) begin
                st_d.rdata = st_q.cfg_word;
            end else begin
                st_d.rdata = 8'h00;
            end
        end
        // hardware set wins over a clearing write
        if (ext_hit) begin
            st_d.irqctl[SWC_IC_EXT_EDGE_FLAG] = 1'b1;
        end
        if (timer_zero_rollover) begin
            st_d.irqctl[SWC_IC_TIMER_ZERO_OVERFLOW_FLAG] = 1'b1;
        end
        if (port_hit) begin
            st_d.irqctl[SWC_IC_PORT_CHANGE_FLAG] = 1'b1;
        end
        if (retfie_instr) begin
            st_d.irqctl[SWC_IC_GIE] = 1'b1;
        end
        if (wdt_clear || !wdt_on) begin
            st_d.wdt_cnt = 16'h0000;
            if (st_q.option[SWC_OPT_PSA] || !wdt_on) begin
                st_d.pre_cnt = 7'h00;
            end
        end else begin
            if (rc_tick && st_q.option[SWC_OPT_PSA]) begin
                st_d.pre_cnt = (st_q.pre_cnt >= pre_lim)
                               ? 7'h00 : st_q.pre_cnt + 7'h01;
            end
            if (wdt_tick) begin
                st_d.wdt_cnt = wdt_timeout ? 16'h0000
                                           : st_q.wdt_cnt + 16'h0001;
            end
        end
        // interrupt countdown to the vector
        if (st_q.irq_pend) begin
            if (st_q.irq_wait == 4'h0) begin
                st_d.irq_vector        = 1'b1;
                st_d.irq_pend          = 1'b0;
                st_d.irqctl[SWC_IC_GIE] = 1'b0;
            end else begin
                st_d.irq_wait = st_q.irq_wait - 4'h1;
            end
        end
        case (st_q.mode)
            SWC_RUN: begin
                if (wdt_timeout) begin
                    st_d.reset_req = 1'b1;
                    st_d.to_n      = 1'b0;
                    st_d.option    = SWC_OPTION_RST;
                    st_d.irqctl    = SWC_IRQCTL_RST;
                    st_d.irq_pend  = 1'b0;
                end else if (sleep_go) begin
                    st_d.mode = SWC_ASLEEP;
                    st_d.pd_n = 1'b0;
                    st_d.to_n = 1'b1;
                end else if (!st_q.irq_pend && st_q.phase == 2'h0
                             && st_q.irqctl[SWC_IC_GIE] && irq_any) begin
                    st_d.irq_pend = 1'b1;
                    st_d.irq_wait = 4'(SWC_IRQ_WAIT_CLKS);
                end
            end
            SWC_ASLEEP: begin
                if (wdt_timeout) begin
                    st_d.mode = SWC_RUN;
                    st_d.wake = 1'b1;
                    st_d.to_n = 1'b0;
                end else if (wake_cond) begin
                    // global enable picks vector after prefetch
                    st_d.mode = SWC_RUN;
                    st_d.wake = 1'b1;
                    if (st_q.irqctl[SWC_IC_GIE]) begin
                        st_d.irq_pend = 1'b1;
                        st_d.irq_wait = 4'(SWC_TCY_CLKS);
                    end
                end
            end
            default: begin
                st_d.mode = SWC_RUN;
            end
        endcase
        // master clear resets in any mode
        if (master_clear_n_act) begin
            st_d.mode      = SWC_RUN;
            st_d.reset_req = 1'b1;
            st_d.option    = SWC_OPTION_RST;
            st_d.irqctl    = SWC_IRQCTL_RST;
            st_d.irq_pend  = 1'b0;
            st_d.irq_vector = 1'b0;
            st_d.wake      = 1'b0;
            st_d.wdt_cnt   = 16'h0000;
            st_d.pre_cnt   = 7'h00;
        end
    end

    // state register, power-up values under reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q            <= '0;
            st_q.s1         <= 7'h7F;
            st_q.s2         <= 7'h7F;
            st_q.s3         <= 7'h7F;
            st_q.filt       <= 7'h7F;
            st_q.prev       <= 7'h7F;
            st_q.mode       <= SWC_RUN;
            st_q.option     <= SWC_OPTION_RST;
            st_q.irqctl     <= SWC_IRQCTL_RST;
            st_q.cfg_word   <= SWC_CONFIG_RST;
            st_q.pd_n       <= 1'b1;
            st_q.to_n       <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign reg_rdata        = st_q.rdata;
    assign irq_vector_load  = st_q.irq_vector;
    // only the return counter is pushed
    assign push_return_pc   = st_q.irq_vector;
    assign vector_addr      = SWC_VECTOR_ADDR;
    assign wake_pulse       = st_q.wake;
    assign device_reset_req = st_q.reset_req;
    assign sleep_active     = (st_q.mode == SWC_ASLEEP);
    assign osc_drive_en     = (st_q.mode == SWC_RUN);
    assign io_hold          = (st_q.mode == SWC_ASLEEP);

    // checks
    sequence s_pend_start;
        $rose(st_q.irq_pend);
    endsequence

    sequence s_vector_soon;
        ##[1:8] st_q.irq_vector;
    endsequence

    property p_edge_flag;
        @(posedge clk) disable iff (!rst_n)
        ext_hit && !master_clear_n_act && !(wdt_timeout && st_q.mode == SWC_RUN)
        |=> st_q.irqctl[SWC_IC_EXT_EDGE_FLAG];
    endproperty
    a_edge_flag: assert property (p_edge_flag)
        else $error("external edge did not set its flag");

    property p_wrong_edge;
        @(posedge clk) disable iff (!rst_n)
        !st_q.option[SWC_OPT_EDGE] && st_q.filt[SWC_PIN_EXT]
        && !st_q.prev[SWC_PIN_EXT] && !st_q.irqctl[SWC_IC_EXT_EDGE_FLAG]
        && !reg_wr |=> !st_q.irqctl[SWC_IC_EXT_EDGE_FLAG];
    endproperty
    a_wrong_edge: assert property (p_wrong_edge)
        else $error("rising edge set flag with falling select");

    property p_t0_flag;
        @(posedge clk) disable iff (!rst_n)
        timer_zero_rollover && !master_clear_n_act
        && !(wdt_timeout && st_q.mode == SWC_RUN) |=> st_q.irqctl[SWC_IC_TIMER_ZERO_OVERFLOW_FLAG];
    endproperty
    a_t0_flag: assert property (p_t0_flag)
        else $error("rollover did not set its flag");

    property p_port_flag;
        @(posedge clk) disable iff (!rst_n)
        port_hit && !master_clear_n_act && !(wdt_timeout && st_q.mode == SWC_RUN)
        |=> st_q.irqctl[SWC_IC_PORT_CHANGE_FLAG];
    endproperty
    a_port_flag: assert property (p_port_flag)
        else $error("port change did not set its flag");

    property p_run_timeout;
        @(posedge clk) disable iff (!rst_n)
        wdt_timeout && st_q.mode == SWC_RUN
        |=> device_reset_req && !st_q.to_n && !wake_pulse;
    endproperty
    a_run_timeout: assert property (p_run_timeout)
        else $error("running time-out did not reset");

    property p_sleep_timeout;
        @(posedge clk) disable iff (!rst_n)
        wdt_timeout && st_q.mode == SWC_ASLEEP && !master_clear_n_act
        |=> wake_pulse && !device_reset_req && !st_q.to_n && osc_drive_en;
    endproperty
    a_sleep_timeout: assert property (p_sleep_timeout)
        else $error("sleeping time-out did not wake");

    property p_fuse_off;
        @(posedge clk) disable iff (!rst_n)
        st_q.cfg_loaded && !st_q.cfg_word[SWC_CFG_WATCHDOG_ENABLE_FUSE]
        |=> st_q.wdt_cnt == 16'h0000 && !wdt_timeout;
    endproperty
    a_fuse_off: assert property (p_fuse_off)
        else $error("watchdog ran with fuse cleared");

    property p_clear_watchdog_instr;
        @(posedge clk) disable iff (!rst_n)
        clear_watchdog_instr |=> st_q.wdt_cnt == 16'h0000;
    endproperty
    a_clear_watchdog_instr: assert property (p_clear_watchdog_instr)
        else $error("clear instruction left counter running");

    property p_sleep_entry;
        @(posedge clk) disable iff (!rst_n)
        sleep_go && !master_clear_n_act && !wdt_timeout
        |=> !st_q.pd_n && st_q.to_n && !osc_drive_en && io_hold
            && st_q.wdt_cnt == 16'h0000;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep entry effects missing");

    property p_latency;
        @(posedge clk) disable iff (!rst_n || master_clear_n_act)
        s_pend_start |-> s_vector_soon;
    endproperty
    a_latency: assert property (p_latency)
        else $error("vector not reached in time");

    property p_vector_gie;
        @(posedge clk) disable iff (!rst_n)
        irq_vector_load |-> !st_q.irqctl[SWC_IC_GIE] && push_return_pc;
    endproperty
    a_vector_gie: assert property (p_vector_gie)
        else $error("global enable still set at vector");

    property p_wake_vector;
        @(posedge clk) disable iff (!rst_n || master_clear_n_act)
        st_q.mode == SWC_ASLEEP && wake_cond && !wdt_timeout
        && st_q.irqctl[SWC_IC_GIE] |=> wake_pulse ##0 s_vector_soon;
    endproperty
    a_wake_vector: assert property (p_wake_vector)
        else $error("enabled wake did not vector");
endmodule : swc_sleep_watchdog_wake_control

/* test/sleep_watchdog_wake_control_tb_top.sv */
// bench for the sleep, watchdog and wake controller
`timescale 1ns/1ps
module sleep_watchdog_wake_control_tb_top;
    import swc_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, ext, master_clear_n_n, rc, pw;
    logic        vec, push, wake, rreq, slp, osc, hold;
    logic [13:0] reg_addr;
    logic [12:0] vaddr;
    logic [7:0]  reg_wdata, reg_rdata, fuse;
    logic [3:0]  ev, pb;
    logic [7:0]  mdl [int];
    int          num_errors, cmp_count, cyc, n, seed;

    swc_far_model u_far (.clk(clk), .ext_edge_pin(ext), .port_b_hi(pb),
        .master_clear_n(master_clear_n_n), .wdt_rc_osc(rc));
    swc_sleep_watchdog_wake_control #(.RC_KHZ(1)) u_dut (.clk(clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_edge_pin(ext), .port_b_hi(pb), .master_clear_n(master_clear_n_n),
        .wdt_rc_osc(rc), .clear_watchdog_instr(ev[0]),
        .sleep_instr(ev[1]), .retfie_instr(ev[2]),
        .timer_zero_rollover(ev[3]), .periph_wake_req(pw),
        .cfg_fuse_bits(fuse), .irq_vector_load(vec),
        .push_return_pc(push), .vector_addr(vaddr), .wake_pulse(wake),
        .device_reset_req(rreq), .sleep_active(slp),
        .osc_drive_en(osc), .io_hold(hold));

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one-cycle register write, model follows
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == SWC_OFF_OPTION || a == SWC_OFF_IRQCTL)
            mdl[a] = d;
    endtask : wr
    // read, data taken the cycle after the strobe
    task automatic rd(input logic [13:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(mdl[a]));
    endtask : rd
    // event pulse: 0 clear, 1 sleep, 2 return, 3 rollover
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask : pulse
    // bounded wait: 0 vector, 1 wake, 2 reset request
    task automatic wait_for(input int w, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (!(w == 0 ? vec : w == 1 ? wake : rreq) && n < lim);
    endtask : wait_for
    task automatic finish_test;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        {rst_n, reg_wr, reg_rd, pw, ev, reg_addr, reg_wdata} = '0;
        {num_errors, cmp_count, cyc} = '0;
        seed = 32'h2436;
        fuse = 8'h04;
        mdl[SWC_OFF_OPTION] = 8'hFF;
        mdl[SWC_OFF_IRQCTL] = 8'h00;
        mdl[SWC_OFF_STATUS] = 8'h18;
        mdl[SWC_OFF_CONFIG] = 8'h04;
        mdl[14'h0050] = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (mdl[a]) rd(14'(a));
        wr(SWC_OFF_OPTION, 8'($random(seed)) | 8'h08);
        rd(SWC_OFF_OPTION);
        wr(SWC_OFF_STATUS, 8'h00);
        wr(SWC_OFF_CONFIG, 8'hFF);
        rd(SWC_OFF_STATUS);
        rd(SWC_OFF_CONFIG);
        pulse(0);
        wr(SWC_OFF_OPTION, 8'hFF);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            wr(SWC_OFF_OPTION, {1'b1, p[0], 6'h3F});
            u_far.drive(!p[0], 4'hF, 1'b1);
            repeat (10) @(posedge clk);
            wr(SWC_OFF_IRQCTL, 8'h00);
            u_far.drive(p[0], 4'hF, 1'b1);
            repeat (10) @(posedge clk);
            mdl[SWC_OFF_IRQCTL] = 8'h02;
            rd(SWC_OFF_IRQCTL);
            wr(SWC_OFF_IRQCTL, 8'h00);
            u_far.drive(!p[0], 4'hF, 1'b1);
            repeat (10) @(posedge clk);
            rd(SWC_OFF_IRQCTL);
        end
        u_far.drive(1'b0, 4'($random(seed)) & 4'hE, 1'b1);
        pulse(3);
        repeat (10) @(posedge clk);
        mdl[SWC_OFF_IRQCTL] = 8'h05;
        rd(SWC_OFF_IRQCTL);
        $display("test flags done");
        wr(SWC_OFF_IRQCTL, 8'h90);
        u_far.drive(1'b1, pb, 1'b1);
        wait_for(0, 30);
        chk({vec, push, vaddr}, {2'b11, SWC_VECTOR_ADDR});
        chk(16'(n >= 12 && n <= 16), 16'h0001);
        mdl[SWC_OFF_IRQCTL] = 8'h12;
        rd(SWC_OFF_IRQCTL);
        wr(SWC_OFF_IRQCTL, 8'h10);
        pulse(2);
        mdl[SWC_OFF_IRQCTL] = 8'h90;
        rd(SWC_OFF_IRQCTL);
        wr(SWC_OFF_IRQCTL, 8'h10);
        $display("test vector done");
        pulse(0);
        pulse(1);
        #1 chk({slp, osc, hold}, 3'b101);
        mdl[SWC_OFF_STATUS] = 8'h10;
        rd(SWC_OFF_STATUS);
        u_far.drive(1'b0, pb, 1'b1);
        repeat (20) @(posedge clk);
        #1 chk(slp, 1'b1);
        u_far.drive(1'b1, pb, 1'b1);
        wait_for(1, 20);
        chk(wake, 1'b1);
        wait_for(0, 20);
        chk({vec, slp}, 2'b00);
        wr(SWC_OFF_IRQCTL, 8'hE0);
        pulse(0);
        pulse(1);
        pulse(3);
        repeat (4) @(posedge clk);
        #1 chk(slp, 1'b1);
        @(posedge clk);
        pw <= 1'b1;
        wait_for(1, 10);
        chk(wake, 1'b1);
        wait_for(0, 20);
        chk(vec, 1'b1);
        @(posedge clk);
        pw <= 1'b0;
        wr(SWC_OFF_IRQCTL, 8'h00);
        $display("test sleep done");
        pulse(0);
        wr(SWC_OFF_OPTION, 8'h40);
        wait_for(2, 400);
        chk(16'(n >= 230 && n <= 300), 16'h0001);
        mdl[SWC_OFF_STATUS] = 8'h00;
        mdl[SWC_OFF_OPTION] = 8'hFF;
        rd(SWC_OFF_STATUS);
        rd(SWC_OFF_OPTION);
        pulse(0);
        wr(SWC_OFF_OPTION, 8'h40);
        pulse(1);
        mdl[SWC_OFF_STATUS] = 8'h10;
        rd(SWC_OFF_STATUS);
        wait_for(1, 400);
        chk({wake, rreq}, 2'b10);
        mdl[SWC_OFF_STATUS] = 8'h00;
        rd(SWC_OFF_STATUS);
        $display("test watchdog done");
        pulse(0);
        wr(SWC_OFF_OPTION, 8'hFF);
        pulse(1);
        u_far.drive(1'b1, pb, 1'b0);
        wait_for(2, 10);
        chk(rreq, 1'b1);
        u_far.drive(1'b1, pb, 1'b1);
        repeat (10) @(posedge clk);
        #1 chk(slp, 1'b0);
        mdl[SWC_OFF_STATUS] = 8'h10;
        rd(SWC_OFF_STATUS);
        $display("test master clear done");
        @(posedge clk);
        rst_n <= 1'b0;
        fuse <= 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        wr(SWC_OFF_OPTION, 8'h40);
        wait_for(2, 400);
        chk(rreq, 1'b0);
        mdl[SWC_OFF_CONFIG] = 8'h00;
        rd(SWC_OFF_CONFIG);
        $display("test fuse off done");
        finish_test();
    end
endmodule : sleep_watchdog_wake_control_tb_top

/* test/swc_far_model.sv */
// far-side model: wake pins, master clear and watchdog oscillator
`timescale 1ns/1ps
module swc_far_model #(
    parameter int RC_HALF_NS = 36
) (
    // clock for pin timing
    input  wire logic       clk,
    // pins toward the device
    output logic            ext_edge_pin,
    output logic [3:0]      port_b_hi,
    output logic            master_clear_n,
    output logic            wdt_rc_osc
);
    initial begin
        wdt_rc_osc = 1'b0;
        #3;
        forever #(RC_HALF_NS) wdt_rc_osc = ~wdt_rc_osc;
    end
    // idle pins match the synchroniser reset level
    initial begin
        ext_edge_pin = 1'b1;
        port_b_hi = 4'hF;
        master_clear_n = 1'b1;
    end
    // pin changes land just after a clock edge
    task automatic drive(input logic e, input logic [3:0] p, input logic m);
        @(posedge clk);
        ext_edge_pin <= e;
        port_b_hi <= p;
        master_clear_n <= m;
    endtask : drive
endmodule : swc_far_model
